/* logic/rwp_pkg.sv */
// Shared constants, states and carriers for the write-command programmer.
// Assumes a 50 MHz system clock and an APB register port with 12-bit byte addresses.
package rwp_pkg;
    localparam int          CLK_HZ        = 50_000_000;
    localparam int          PROG_TIME_MS  = 16;
    localparam int          PROG_CYC_DEF  = PROG_TIME_MS * (CLK_HZ / 1000);
    localparam int          PROG_CNT_W    = 24;

    // Interval limits and delays, in field clocks
    localparam logic [6:0]  ZERO_MIN      = 7'h10;
    localparam logic [6:0]  ZERO_MAX      = 7'h20;
    localparam logic [6:0]  ONE_MIN       = 7'h30;
    localparam logic [6:0]  ONE_MAX       = 7'h40;
    localparam logic [6:0]  GAP_TIMEOUT   = 7'h40;
    localparam logic [5:0]  PRE_PROG_CLKS = 6'h20;

    // Accepted frame lengths in bits, and the overlength marker LEN_OVER
    localparam logic [6:0]  LEN_STOP      = 7'h02;
    localparam logic [6:0]  LEN_WAKE      = 7'h22;
    localparam logic [6:0]  LEN_STD       = 7'h26;
    localparam logic [6:0]  LEN_PWD       = 7'h46;
    localparam logic [6:0]  LEN_OVER      = 7'h47;
    localparam int          RX_BITS       = 70;

    localparam logic [1:0]  OP_WRITE      = 2'h2;
    localparam logic [1:0]  OP_STOP       = 2'h3;
    localparam logic [2:0]  BLK_CFG       = 3'h0;
    localparam logic [2:0]  BLK_FIRST     = 3'h1;
    localparam logic [2:0]  BLK_PWD       = 3'h7;

    // Register map (byte addresses)
    localparam logic [11:0] OFF_CTRL      = 12'h000;
    localparam logic [11:0] OFF_STATUS    = 12'h004;
    localparam logic [11:0] OFF_LOCKS     = 12'h008;
    localparam logic [6:0]  OFF_BLK_BASE  = 7'h01;   // paddr[11:5]: blocks at 0x020..0x03C
    localparam int          CTRL_PWD_EN   = 0;
    localparam int          CTRL_AOR      = 1;
    localparam int          CTRL_BT_EN    = 2;
    localparam int          CTRL_ST_EN    = 3;
    localparam logic [3:0]  CTRL_RST      = 4'h0;
    localparam logic [7:0]  LOCKS_RST     = 8'h00;
    localparam logic [31:0] BLK_RST       = 32'h0000_0000;

    typedef enum logic [2:0] {
        ST_READ  = 3'b000,
        ST_WRITE = 3'b001,
        ST_PRE   = 3'b010,
        ST_PROG  = 3'b011,
        ST_STOP  = 3'b100
    } rwp_state_e;

    typedef enum logic [1:0] {
        ERR_NONE   = 2'b00,
        ERR_GAP    = 2'b01,
        ERR_FRAME  = 2'b10,
        ERR_PROG   = 2'b11
    } rwp_err_e;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } rwp_apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } rwp_apb_rsp_s;

    typedef struct packed {
        rwp_state_e                 st;
        logic [2:0]                 fclk_s;
        logic [2:0]                 gap_s;
        logic [1:0]                 vpp_s;
        logic [6:0]                 fcnt;
        logic [6:0]                 nbits;
        logic [RX_BITS-1:0]         rx;
        logic [5:0]                 pre_cnt;
        logic [PROG_CNT_W-1:0]      prog_cnt;
        logic [2:0]                 addr;
        logic                       lock_bit;
        logic [31:0]                data;
        logic [7:0][31:0]           mem;
        logic [7:0]                 locks;
        logic [3:0]                 ctrl;
        logic                       woke;
        logic [2:0]                 read_blk;
        logic                       restart;
        logic                       term_first;
        logic                       cfg_pending;
        logic [31:0]                cfg_word;
        rwp_err_e                   err;
        logic [31:0]                prdata;
    } rwp_state_s;
endpackage

/* logic/rwp_programmer.sv */
// Write-command decoder and EEPROM programming sequencer of a 125 kHz transponder.
// Field clock, gap detector and Vpp status come from analog pins and are synchronised here;
// the read-out modulator sits outside and follows read_block, read_restart and mod_en.
//
// Behaviour
// - Opcode first; only 10 and 11 valid
// - Invalid opcode: read from block 1
// - Answer-on-request: modulate after matching password
// - Stop opcode silences until power-on reset
// - Stop with extra bits is not stop
// - Data read back in write order
// - Password compared against block 7 from bit 1
// - Password mismatch: no programming, read block 1
// - Password bits accepted when password mode off
// - 32 field clocks, check Vpp and lock
// - Vpp low anytime: read mode at once
// - Programming lasts 16 ms
// - After programming, send programmed block first
// - Terminators enabled: block terminator precedes it
// - New configuration only after that block
// - Valid lengths 38, 70, 34, 2 bits
// - Write error: skip programming, read block 1
// - Lock or Vpp fail: read addressed block
// - Interval 16-32 zero, 48-64 one
// - No gap for 64 clocks ends write
// - First gap enters write; damping held
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ps
module rwp_programmer
    import rwp_pkg::*;
#(
    parameter int PROG_CYC = PROG_CYC_DEF
) (
    input  wire logic         clk_sys,       // 50 MHz system clock
    input  wire logic         sys_rst,       // Asynchronous reset, active high
    input  wire logic         field_clk,     // Recovered carrier clock, asynchronous
    input  wire logic         gap_det,       // Field gap detected, asynchronous level
    input  wire logic         vpp_ok,        // Programming voltage sufficient, asynchronous
    input  wire logic         block_sent,    // Modulator finished one block, pulse
    input  wire rwp_apb_req_s apb_req,       // APB request
    output rwp_apb_rsp_s      apb_rsp,       // APB response
    output logic              force_damp,    // Load damping held on during write
    output logic              mod_en,        // Modulation allowed
    output logic [2:0]        read_block,    // Block to transmit first after restart
    output logic              read_restart,  // Restart read-out, pulse
    output logic              term_first,    // Block terminator before first block
    output logic [31:0]       cfg_active     // Configuration in force
);

    rwp_state_s r_reg;
    rwp_state_s r_next;

    logic        fedge;
    logic        gedge;
    logic        vpp;
    logic [1:0]  opcode;
    logic        pwd_match;
    logic        eval;
    logic        is_zero;
    logic        is_one;
    logic        apb_acc;
    logic        apb_blk;
    logic        apb_hit;
    logic [2:0]  apb_idx;

    // The first stage of each synchroniser feeds only its second stage
    assign fedge     = r_reg.fclk_s[1] & ~r_reg.fclk_s[2];
    assign gedge     = r_reg.gap_s[1] & ~r_reg.gap_s[2];
    assign vpp       = r_reg.vpp_s[1];
    assign opcode    = r_reg.rx[RX_BITS-1 -: 2];
    assign pwd_match = (r_reg.rx[RX_BITS-3 -: 32] == r_reg.mem[BLK_PWD]);
    // A gap on the timeout edge is a valid one, so it must not also end the frame
    assign eval      = (r_reg.st == ST_WRITE) && fedge && !gedge && (r_reg.fcnt == GAP_TIMEOUT);
    assign is_zero   = (r_reg.fcnt >= ZERO_MIN) && (r_reg.fcnt <= ZERO_MAX);
    assign is_one    = (r_reg.fcnt >= ONE_MIN) && (r_reg.fcnt <= ONE_MAX);

    assign apb_acc   = apb_req.psel & apb_req.penable;
    assign apb_blk   = (apb_req.paddr[11:5] == OFF_BLK_BASE) && (apb_req.paddr[1:0] == 2'h0);
    assign apb_idx   = apb_req.paddr[4:2];
    assign apb_hit   = apb_blk || (apb_req.paddr == OFF_CTRL) ||
                       (apb_req.paddr == OFF_STATUS) || (apb_req.paddr == OFF_LOCKS);

    always_comb begin
        r_next         = r_reg;
        r_next.restart = 1'b0;
        r_next.fclk_s  = {r_reg.fclk_s[1:0], field_clk};
        r_next.gap_s   = {r_reg.gap_s[1:0], gap_det};
        r_next.vpp_s   = {r_reg.vpp_s[0], vpp_ok};

        if (fedge && r_reg.fcnt != 7'h7F) begin
            r_next.fcnt = r_reg.fcnt + 7'h01;
        end

        // Old mode stays in force until the programmed block has gone out
        if (r_reg.cfg_pending && block_sent) begin
            r_next.cfg_word    = r_reg.mem[BLK_CFG];
            r_next.cfg_pending = 1'b0;
        end
        if (r_reg.term_first && block_sent) begin
            r_next.term_first = 1'b0;
        end

        case (r_reg.st)
            ST_READ: begin
                if (gedge) begin
                    r_next.st    = ST_WRITE;
                    r_next.fcnt  = 7'h00;
                    r_next.nbits = 7'h00;
                    r_next.rx    = '0;
                end
            end
            ST_WRITE: begin
                if (gedge) begin
                    r_next.fcnt = 7'h00;
                    if (is_zero || is_one) begin
                        if (r_reg.nbits < LEN_PWD) begin
                            r_next.rx[7'(RX_BITS-1) - r_reg.nbits] = is_one;
                            r_next.nbits = r_reg.nbits + 7'h01;
                        end else begin
                            r_next.nbits = LEN_OVER;
                        end
                    end else begin
                        r_next.st       = ST_READ;
                        r_next.read_blk = BLK_FIRST;
                        r_next.restart  = 1'b1;
                        r_next.err      = ERR_GAP;
                    end
                end else if (eval) begin
                    r_next.st       = ST_READ;
                    r_next.read_blk = BLK_FIRST;
                    r_next.restart  = 1'b1;
                    r_next.err      = ERR_FRAME;
                    if (opcode == OP_STOP && r_reg.nbits == LEN_STOP) begin
                        r_next.st      = ST_STOP;
                        r_next.restart = 1'b0;
                        r_next.err     = ERR_NONE;
                    end else if (opcode == OP_WRITE) begin
                        if (r_reg.nbits == LEN_WAKE && r_reg.ctrl[CTRL_PWD_EN] && pwd_match) begin
                            r_next.woke = 1'b1;
                            r_next.err  = ERR_NONE;
                        end else if (r_reg.nbits == LEN_STD && !r_reg.ctrl[CTRL_PWD_EN]) begin
                            r_next.st       = ST_PRE;
                            r_next.restart  = 1'b0;
                            r_next.err      = ERR_NONE;
                            r_next.lock_bit = r_reg.rx[RX_BITS-3];
                            r_next.data     = r_reg.rx[RX_BITS-4 -: 32];
                            r_next.addr     = r_reg.rx[RX_BITS-36 -: 3];
                        end else if (r_reg.nbits == LEN_PWD &&
                                     (pwd_match || !r_reg.ctrl[CTRL_PWD_EN])) begin
                            r_next.st       = ST_PRE;
                            r_next.restart  = 1'b0;
                            r_next.err      = ERR_NONE;
                            r_next.lock_bit = r_reg.rx[RX_BITS-35];
                            r_next.data     = r_reg.rx[RX_BITS-36 -: 32];
                            r_next.addr     = r_reg.rx[2:0];
                        end
                        // Any other length or a mismatch falls back to block 1
                    end
                    r_next.pre_cnt  = 6'h00;
                    r_next.prog_cnt = '0;
                end
            end
            ST_PRE: begin
                if (!vpp || r_reg.locks[r_reg.addr]) begin
                    r_next.st       = ST_READ;
                    r_next.read_blk = r_reg.addr;
                    r_next.restart  = 1'b1;
                    r_next.err      = ERR_PROG;
                end else if (fedge) begin
                    if (r_reg.pre_cnt == PRE_PROG_CLKS - 6'h01) begin
                        r_next.st = ST_PROG;
                    end
                    r_next.pre_cnt = r_reg.pre_cnt + 6'h01;
                end
            end
            ST_PROG: begin
                if (!vpp) begin
                    r_next.st       = ST_READ;
                    r_next.read_blk = r_reg.addr;
                    r_next.restart  = 1'b1;
                    r_next.err      = ERR_PROG;
                end else if (r_reg.prog_cnt == PROG_CNT_W'(PROG_CYC - 1)) begin
                    r_next.st                  = ST_READ;
                    r_next.mem[r_reg.addr]     = r_reg.data;
                    r_next.locks[r_reg.addr]   = r_reg.lock_bit;
                    r_next.read_blk            = r_reg.addr;
                    r_next.restart             = 1'b1;
                    r_next.term_first          = r_reg.ctrl[CTRL_BT_EN] |
                                                 r_reg.ctrl[CTRL_ST_EN];
                    // A mode change still waiting for its block must not be lost
                    r_next.cfg_pending         = r_next.cfg_pending |
                                                 (r_reg.addr == BLK_CFG);
                end else begin
                    r_next.prog_cnt = r_reg.prog_cnt + PROG_CNT_W'(1);
                end
            end
            ST_STOP: begin
                r_next.st = ST_STOP;
            end
            default: begin
                r_next.st = ST_READ;
            end
        endcase

        // Register port; the sequencer's own updates above take priority on a block
        if (apb_req.psel && !apb_req.penable) begin
            r_next.prdata = 32'h0000_0000;
            if (apb_blk) begin
                r_next.prdata = r_reg.mem[apb_idx];
            end else if (apb_req.paddr == OFF_CTRL) begin
                r_next.prdata = {28'h000_0000, r_reg.ctrl};
            end else if (apb_req.paddr == OFF_STATUS) begin
                r_next.prdata = {17'h0_0000, r_reg.nbits, 1'b0, r_reg.err,
                                 r_reg.cfg_pending, r_reg.woke, r_reg.st};
            end else if (apb_req.paddr == OFF_LOCKS) begin
                r_next.prdata = {24'h00_0000, r_reg.locks};
            end
        end
        if (apb_acc && apb_req.pwrite) begin
            if (apb_req.paddr == OFF_CTRL) begin
                r_next.ctrl = apb_req.pwdata[3:0];
            end else if (apb_req.paddr == OFF_LOCKS) begin
                r_next.locks = apb_req.pwdata[7:0];
            end else if (apb_blk && !(r_reg.st == ST_PROG && r_reg.addr == apb_idx)) begin
                r_next.mem[apb_idx] = apb_req.pwdata;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            r_reg          <= '0;
            r_reg.st       <= ST_READ;
            r_reg.err      <= ERR_NONE;
            r_reg.ctrl     <= CTRL_RST;
            r_reg.locks    <= LOCKS_RST;
            r_reg.mem      <= {8{BLK_RST}};
            r_reg.cfg_word <= BLK_RST;
            r_reg.read_blk <= BLK_FIRST;
        end else begin
            r_reg <= r_next;
        end
    end

    assign apb_rsp.prdata  = r_reg.prdata;
    assign apb_rsp.pready  = 1'b1;
    assign apb_rsp.pslverr = apb_acc & ~apb_hit;

    assign force_damp   = (r_reg.st == ST_WRITE);
    assign mod_en       = (r_reg.st != ST_STOP) &&
                          (!r_reg.ctrl[CTRL_AOR] || r_reg.woke);
    assign read_block   = r_reg.read_blk;
    assign read_restart = r_reg.restart;
    assign term_first   = r_reg.term_first;
    assign cfg_active   = r_reg.cfg_word;

    sequence s_stop_taken;
        eval && opcode == OP_STOP && r_reg.nbits == LEN_STOP;
    endsequence
    sequence s_silent;
        (!force_damp && !mod_en)[*8];
    endsequence
    sequence s_prog_done;
        r_reg.st == ST_PROG && vpp && r_reg.prog_cnt == PROG_CNT_W'(PROG_CYC - 1);
    endsequence

    property p_gap_enters_write;
        @(posedge clk_sys) disable iff (sys_rst)
        (r_reg.st == ST_READ && gedge) |=> force_damp;
    endproperty
    a_gap_enters_write: assert property (p_gap_enters_write) else $error("gap ignored");

    property p_bad_opcode;
        @(posedge clk_sys) disable iff (sys_rst)
        (eval && opcode != OP_WRITE && opcode != OP_STOP)
            |=> (read_restart && read_block == BLK_FIRST && r_reg.st == ST_READ);
    endproperty
    a_bad_opcode: assert property (p_bad_opcode) else $error("bad opcode kept");

    property p_stop;
        @(posedge clk_sys) disable iff (sys_rst)
        s_stop_taken |=> s_silent;
    endproperty
    a_stop: assert property (p_stop) else $error("stop did not silence");

    property p_stop_extra;
        @(posedge clk_sys) disable iff (sys_rst)
        (eval && opcode == OP_STOP && r_reg.nbits != LEN_STOP) |=> r_reg.st != ST_STOP;
    endproperty
    a_stop_extra: assert property (p_stop_extra) else $error("stop with extra bits taken");

    property p_bad_length;
        @(posedge clk_sys) disable iff (sys_rst)
        (eval && opcode == OP_WRITE && r_reg.nbits != LEN_STD && r_reg.nbits != LEN_PWD &&
         r_reg.nbits != LEN_WAKE) |=> (r_reg.st == ST_READ && read_block == BLK_FIRST);
    endproperty
    a_bad_length: assert property (p_bad_length) else $error("bad length not refused");

    property p_interval;
        @(posedge clk_sys) disable iff (sys_rst)
        (r_reg.st == ST_WRITE && gedge && !is_zero && !is_one)
            |=> (r_reg.st == ST_READ && read_restart && read_block == BLK_FIRST);
    endproperty
    a_interval: assert property (p_interval) else $error("bad interval accepted");

    property p_timeout;
        @(posedge clk_sys) disable iff (sys_rst)
        (r_reg.st == ST_WRITE && r_reg.fcnt > GAP_TIMEOUT) |-> ##[0:1] r_reg.st != ST_WRITE;
    endproperty
    a_timeout: assert property (p_timeout) else $error("write mode outlived timeout");

    property p_pre_delay;
        @(posedge clk_sys) disable iff (sys_rst)
        (r_reg.st == ST_PRE && $past(r_reg.st) == ST_PRE && r_next.st == ST_PROG)
            |-> (r_reg.pre_cnt == PRE_PROG_CLKS - 6'h01 && vpp);
    endproperty
    a_pre_delay: assert property (p_pre_delay) else $error("programming began early");

    property p_lock_refuse;
        @(posedge clk_sys) disable iff (sys_rst)
        (r_reg.st == ST_PRE && r_reg.locks[r_reg.addr])
            |=> (r_reg.st == ST_READ && read_block == $past(r_reg.addr));
    endproperty
    a_lock_refuse: assert property (p_lock_refuse) else $error("locked block programmed");

    property p_vpp_low;
        @(posedge clk_sys) disable iff (sys_rst)
        (r_reg.st == ST_PROG && !vpp) |=> (r_reg.st == ST_READ && read_restart);
    endproperty
    a_vpp_low: assert property (p_vpp_low) else $error("Vpp loss ignored");

    property p_prog_done;
        @(posedge clk_sys) disable iff (sys_rst)
        (r_reg.st == ST_PROG && vpp && r_reg.prog_cnt == PROG_CNT_W'(PROG_CYC - 1))
            |=> (read_block == $past(r_reg.addr) && read_restart &&
                 r_reg.mem[read_block] == $past(r_reg.data));
    endproperty
    a_prog_done: assert property (p_prog_done) else $error("block not sent first");

    property p_cfg_hold;
        @(posedge clk_sys) disable iff (sys_rst)
        (r_reg.cfg_pending && !block_sent) |=> $stable(cfg_active);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("new mode applied early");

    property p_pwd_refuse;
        @(posedge clk_sys) disable iff (sys_rst)
        (eval && opcode == OP_WRITE && r_reg.ctrl[CTRL_PWD_EN] && !pwd_match)
            |=> (r_reg.st == ST_READ && read_restart && read_block == BLK_FIRST);
    endproperty
    a_pwd_refuse: assert property (p_pwd_refuse) else $error("bad password accepted");

    property p_wake;
        @(posedge clk_sys) disable iff (sys_rst)
        (eval && opcode == OP_WRITE && r_reg.nbits == LEN_WAKE && r_reg.ctrl[CTRL_PWD_EN] &&
         pwd_match) |=> mod_en;
    endproperty
    a_wake: assert property (p_wake) else $error("wake-up did not enable modulation");

    property p_std_accept;
        @(posedge clk_sys) disable iff (sys_rst)
        (eval && opcode == OP_WRITE && r_reg.nbits == LEN_STD && !r_reg.ctrl[CTRL_PWD_EN])
            |=> (r_reg.st == ST_PRE && !read_restart);
    endproperty
    a_std_accept: assert property (p_std_accept) else $error("standard write refused");

    property p_term_first;
        @(posedge clk_sys) disable iff (sys_rst)
        s_prog_done ##0 (r_reg.ctrl[CTRL_BT_EN] || r_reg.ctrl[CTRL_ST_EN]) |=> term_first;
    endproperty
    a_term_first: assert property (p_term_first) else $error("terminator not requested");

    // A register write to the lock word in the same cycle wins, so it is left out
    property p_store;
        @(posedge clk_sys) disable iff (sys_rst)
        s_prog_done ##0 !apb_acc |=> (r_reg.locks[read_block] == $past(r_reg.lock_bit));
    endproperty
    a_store: assert property (p_store) else $error("lock bit not stored");

endmodule // rwp_programmer

/* testbench/rwp_station.sv */
// Base-station model: free-running field clock and gap-coded frames.
// Assumes the tag counts rising field_clk edges between rises of gap_det.
`timescale 1ns/1ps
module rwp_station (
    output logic field_clk, // Carrier clock, 160 ns period
    output logic gap_det    // Field gap, active high
);
    initial begin
        field_clk = 1'b0;
        gap_det   = 1'b0;
        #7;
        forever #80 field_clk = ~field_clk;
    end

    task automatic gap();
        gap_det <= 1'b1;
        repeat (2) @(posedge field_clk);
        gap_det <= 1'b0;
    endtask

    // First bit sent is bits[n-1]; 20 clocks for a zero, 50 for a one,
    // well inside both windows so sync jitter cannot flip a bit
    task automatic send(input logic [69:0] bits, input int n);
        gap();
        for (int i = n - 1; i >= 0; i--) begin
            repeat (bits[i] ? 48 : 18) @(posedge field_clk);
            gap();
        end
    endtask
endmodule // rwp_station

/* testbench/rwp_programmer_test.sv */
// Self-checking bench for the write-command programmer.
// Assumes the station model drives the field; restart blocks are queued.
`timescale 1ns/1ps
module rwp_programmer_test;
    import rwp_pkg::*;
    logic         clk_sys, sys_rst, field_clk, gap_det, vpp_ok, block_sent;
    logic         force_damp, mod_en, read_restart, term_first, err;
    logic [2:0]   read_block;
    logic [31:0]  cfg_active, rd, dat;
    rwp_apb_req_s apb_req;
    rwp_apb_rsp_s apb_rsp;
    logic [2:0]   exp_q[$];
    int           miscompares, checked, seen;
    // Few ones keep the frames short
    localparam logic [31:0] PASSWORD_MODE_BIT = 32'h0000_00F1;
    localparam logic [31:0] CFG = 32'h0000_0091;

    rwp_programmer #(.PROG_CYC(200)) dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .field_clk(field_clk), .gap_det(gap_det), .vpp_ok(vpp_ok), .block_sent(block_sent),
        .apb_req(apb_req), .apb_rsp(apb_rsp), .force_damp(force_damp), .mod_en(mod_en),
        .read_block(read_block), .read_restart(read_restart), .term_first(term_first),
        .cfg_active(cfg_active));
    rwp_station st (.field_clk(field_clk), .gap_det(gap_det));

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        if (miscompares == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge clk_sys);
        apb_req.penable <= 1'b1;
        do @(posedge clk_sys); while (apb_rsp.pready !== 1'b1);
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req <= '0;
        @(posedge clk_sys);
    endtask

    function automatic logic [11:0] ba(input logic [2:0] n);
        return {OFF_BLK_BASE, n, 2'b00};
    endfunction

    // b < 0: no restart expected; waits for write mode to end
    task automatic frame(input logic [69:0] bits, input int n, input int b);
        int t;
        t = seen;
        if (b >= 0) begin
            exp_q.push_back(b[2:0]);
            t++;
        end
        st.send(bits, n);
        cmp(force_damp, 1'b1);
        for (int i = 0; i < 3000 && (force_damp !== 1'b0 || seen < t); i++) @(posedge clk_sys);
        cmp(force_damp === 1'b0 && seen >= t, 1'b1);
    endtask

    always @(posedge clk_sys) begin
        if (read_restart === 1'b1) begin
            seen++;
            // A restart nobody asked for can never match the all-ones word
            cmp(read_block, (exp_q.size() > 0) ? 32'(exp_q.pop_front()) : 32'hFFFF_FFFF);
        end
    end

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    initial begin
        #2_000_000;
        miscompares++;
        print_verdict();
    end

    initial begin
        sys_rst = 1'b1;
        vpp_ok = 1'b1;
        block_sent = 1'b0;
        apb_req = '0;
        void'($urandom(93364));
        dat = $urandom();
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        apb(1'b0, OFF_CTRL, 32'h0);
        cmp(rd, {28'h0, CTRL_RST});
        apb(1'b0, 12'h0FC, 32'h0);
        cmp(err, 1'b1);
        apb(1'b1, OFF_CTRL, 32'h0000_0004);
        frame({2'b10, 1'b0, CFG, 3'h0}, 38, 0);
        cmp(term_first, 1'b1);
        cmp(cfg_active, 32'h0);
        block_sent <= 1'b1;
        @(posedge clk_sys);
        block_sent <= 1'b0;
        @(posedge clk_sys);
        cmp(cfg_active, CFG);
        cmp(term_first, 1'b0);
        frame({2'b10, 1'b1, dat, 3'h3}, 38, 3);
        apb(1'b0, ba(3'h3), 32'h0);
        cmp(rd, dat);
        apb(1'b0, OFF_LOCKS, 32'h0);
        cmp(rd, 32'h0000_0008);
        frame({2'b10, 1'b0, 32'h1, 3'h3}, 38, 3);
        apb(1'b0, ba(3'h3), 32'h0);
        cmp(rd, dat);
        vpp_ok <= 1'b0;
        frame({2'b10, 1'b0, 32'h1, 3'h4}, 38, 4);
        vpp_ok <= 1'b1;
        apb(1'b0, ba(3'h4), 32'h0);
        cmp(rd, 32'h0);
        // Drop Vpp in mid-programming: about 256 cycles of delay, then 200 of programming
        fork
            begin
                wait (force_damp === 1'b1);
                wait (force_damp === 1'b0);
                repeat (350) @(posedge clk_sys);
                vpp_ok <= 1'b0;
            end
        join_none
        frame({2'b10, 1'b0, 32'h8, 3'h4}, 38, 4);
        vpp_ok <= 1'b1;
        apb(1'b0, ba(3'h4), 32'h0);
        cmp(rd, 32'h0);
        frame(2'b01, 2, 1);
        apb(1'b1, ba(3'h7), PASSWORD_MODE_BIT);
        apb(1'b1, OFF_CTRL, 32'h0000_0001);
        frame({2'b10, PASSWORD_MODE_BIT ^ 32'h1, 1'b0, 32'h5, 3'h5}, 70, 1);
        apb(1'b0, ba(3'h5), 32'h0);
        cmp(rd, 32'h0);
        frame({2'b10, PASSWORD_MODE_BIT, 1'b0, 32'h5, 3'h5}, 70, 5);
        apb(1'b0, ba(3'h5), 32'h0);
        cmp(rd, 32'h5);
        apb(1'b1, OFF_CTRL, 32'h0000_0003);
        @(posedge clk_sys);
        cmp(mod_en, 1'b0);
        frame({2'b10, PASSWORD_MODE_BIT}, 34, 1);
        cmp(mod_en, 1'b1);
        frame(3'b110, 3, 1);
        cmp(mod_en, 1'b1);
        frame(2'b11, 2, -1);
        cmp(mod_en, 1'b0);
        cmp(exp_q.size(), 0);
        print_verdict();
    end
endmodule // rwp_programmer_test
